// ---- rtl/bor_seq_pkg.sv ----
// package: constants and types for the brown-out and power-up reset sequencer
package bor_seq_pkg;
   localparam int unsigned CLK_HZ             = 20000000;
   // register byte offsets (chosen layout)
   localparam logic [7:0]  OFS_RESET_CTRL     = 8'h00;
   localparam logic [7:0]  OFS_STATUS         = 8'h04;
   // reset_control_reg field positions
   localparam int          BIT_BOR_FLAG       = 0;
   localparam int          BIT_POR_FLAG       = 1;
   localparam int          BIT_SW_ENABLE      = 6;
   // status register field positions
   localparam int          BIT_ST_BOR_ACTIVE  = 0;
   localparam int          BIT_ST_RESET       = 1;
   localparam int          BIT_ST_BOR_EN      = 2;
   localparam int          BIT_ST_STATE_LSB   = 4;
   // brownout_mode_select encodings
   localparam logic [1:0]  MODE_OFF           = 2'h0;
   localparam logic [1:0]  MODE_SW            = 2'h1;
   localparam logic [1:0]  MODE_NOSLEEP       = 2'h2;
   localparam logic [1:0]  MODE_ON            = 2'h3;
   // timing
   localparam int unsigned POWERUP_DELAY_TIMER_BITS          = 11;
   localparam int unsigned OST_CYCLES         = 1024;
   localparam int unsigned PLL_LOCK_US        = 2000;
   localparam int unsigned PLL_LOCK_CYC       = PLL_LOCK_US * (CLK_HZ / 1000000);
   localparam int unsigned BOR_MIN_NS         = 200;
   localparam int unsigned BOR_MIN_CYC        = (BOR_MIN_NS * (CLK_HZ / 1000000) + 999) / 1000;
   localparam int unsigned SLOW_OSC_US        = 32;
   localparam int unsigned SLOW_OSC_CYC       = SLOW_OSC_US * (CLK_HZ / 1000000);

   typedef enum logic [4:0] {
      ST_BOR  = 5'h01,
      ST_POWERUP_DELAY_TIMER = 5'h02,
      ST_OST  = 5'h04,
      ST_PLL  = 5'h08,
      ST_RUN  = 5'h10
   } seq_state_t;

   typedef struct packed {
      logic [1:0] mode_select;
      logic [1:0] level_select;
      logic       timer_disable_n;
      logic       xtal_mode;
      logic       pll_used;
   } fuse_cfg_t;

   function automatic logic bor_enabled(input logic [1:0] mode, input logic sw_en,
                                        input logic sleeping);
      case (mode)
         MODE_OFF:     bor_enabled = 1'b0;
         MODE_SW:      bor_enabled = sw_en;
         MODE_NOSLEEP: bor_enabled = ~sleeping;
         default:      bor_enabled = 1'b1;
      endcase
   endfunction
endpackage

// ---- rtl/bor_sync_filter.sv ----
// module: two-flop synchroniser plus duration filter for the supply comparator
`timescale 1ns/1ns
module bor_sync_filter
   import bor_seq_pkg::*;
#(
   parameter int unsigned MIN_CYC = 4
) (
   input  wire logic sys_clk_in,
   input  wire logic reset_n_in,
   input  wire logic enable_in,
   input  wire logic below_in,
   output logic      low_raw_out,
   output logic      trip_out
);
   logic        sync1_reg;
   logic        sync2_reg;
   logic [15:0] cnt_reg;

   always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         sync1_reg <= 1'b0;
         sync2_reg <= 1'b0;
      end else begin
         sync1_reg <= below_in;
         sync2_reg <= sync1_reg;
      end
   end

   assign low_raw_out = sync2_reg;

   // glitches shorter than the minimum duration never trip
   always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         cnt_reg  <= 16'h0000;
         trip_out <= 1'b0;
      end else if (!enable_in || !sync2_reg) begin
         cnt_reg  <= 16'h0000;
         trip_out <= 1'b0;
      end else if (cnt_reg >= 16'(MIN_CYC)) begin
         trip_out <= 1'b1;
      end else begin
         cnt_reg <= cnt_reg + 16'h0001;
      end
   end
endmodule

// ---- rtl/bor_reset_seq.sv ----
// module: brown-out detect, power-up delay, oscillator start-up and pll lock sequencer
//
// The register offsets and the APB slave port were chosen for this implementation.
`timescale 1ns/1ns
module bor_reset_seq
   import bor_seq_pkg::*;
#(
   parameter int unsigned PLL_CYC   = PLL_LOCK_CYC,
   parameter int unsigned TICK_CYC  = SLOW_OSC_CYC
) (
   input  wire logic        sys_clk_in,
   input  wire logic        reset_n_in,
   // apb slave
   input  wire logic        psel_in,
   input  wire logic        penable_in,
   input  wire logic        pwrite_in,
   input  wire logic [7:0]  paddr_in,
   input  wire logic [31:0] pwdata_in,
   output logic [31:0]      prdata_out,
   output logic             pready_out,
   output logic             pslverr_out,
   // configuration fuses, static
   input  wire fuse_cfg_t   fuse_in,
   // supply comparator (asynchronous), oscillator clock tick, sleep status
   input  wire logic        supply_below_in,
   input  wire logic        osc_cycle_in,
   input  wire logic        sleep_in,
   output logic [1:0]       trip_level_out,
   output logic             bor_detector_en_out,
   output logic             core_reset_out
);
   seq_state_t  state_reg;
   logic        sw_enable_reg;
   logic        bor_flag_n_reg;
   logic        por_flag_n_reg;
   logic        sleep_s1_reg;
   logic        sleep_s2_reg;
   logic        osc_s1_reg;
   logic        osc_s2_reg;
   logic        osc_s3_reg;
   logic [POWERUP_DELAY_TIMER_BITS-1:0] powerup_delay_timer_cnt_reg;
   logic [11:0] tick_div_reg;
   logic        slow_tick_reg;
   logic [10:0] ost_cnt_reg;
   logic [16:0] pll_cnt_reg;
   logic        por_seen_reg;
   logic        bor_en;
   logic        low_raw;
   logic        bor_trip;
   logic        osc_edge;
   logic        wr_en;
   logic        rd_en;

   always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         sleep_s1_reg <= 1'b0;
         sleep_s2_reg <= 1'b0;
         osc_s1_reg   <= 1'b0;
         osc_s2_reg   <= 1'b0;
         osc_s3_reg   <= 1'b0;
      end else begin
         sleep_s1_reg <= sleep_in;
         sleep_s2_reg <= sleep_s1_reg;
         osc_s1_reg   <= osc_cycle_in;
         osc_s2_reg   <= osc_s1_reg;
         osc_s3_reg   <= osc_s2_reg;
      end
   end

   assign osc_edge = osc_s2_reg & ~osc_s3_reg;

   // detection enable; mode select decides, sleep only matters in mode 10
   assign bor_en = bor_enabled(fuse_in.mode_select, sw_enable_reg, sleep_s2_reg);

   bor_sync_filter #(
      .MIN_CYC     (BOR_MIN_CYC)
   ) u_filter (
      .sys_clk_in  (sys_clk_in),
      .reset_n_in  (reset_n_in),
      .enable_in   (bor_en),
      .below_in    (supply_below_in),
      .low_raw_out (low_raw),
      .trip_out    (bor_trip)
   );

   // trip level comes straight from the fuses, no software path exists
   always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         trip_level_out      <= 2'h0;
         bor_detector_en_out <= 1'b0;
      end else begin
         trip_level_out      <= fuse_in.level_select;
         bor_detector_en_out <= bor_en;
      end
   end

   // slow oscillator tick, one-cycle enable every nominal 32 us period
   always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         tick_div_reg  <= 12'h000;
         slow_tick_reg <= 1'b0;
      end else if (tick_div_reg >= 12'(TICK_CYC - 1)) begin
         tick_div_reg  <= 12'h000;
         slow_tick_reg <= 1'b1;
      end else begin
         tick_div_reg  <= tick_div_reg + 12'h001;
         slow_tick_reg <= 1'b0;
      end
   end

   // sequencer
   always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         state_reg    <= ST_BOR;
         powerup_delay_timer_cnt_reg <= '0;
         ost_cnt_reg  <= 11'h000;
         pll_cnt_reg  <= 17'h00000;
      end else if (bor_trip) begin
         state_reg    <= ST_BOR;
         powerup_delay_timer_cnt_reg <= '0;
      end else begin
         case (state_reg)
            ST_BOR: begin
               powerup_delay_timer_cnt_reg <= '0;
               ost_cnt_reg  <= 11'h000;
               pll_cnt_reg  <= 17'h00000;
               // stay while supply low and detection is on
               if (!(bor_en && low_raw)) begin
                  if (!fuse_in.timer_disable_n)
                     state_reg <= ST_POWERUP_DELAY_TIMER;
                  else if (fuse_in.xtal_mode)
                     state_reg <= ST_OST;
                  else if (fuse_in.pll_used)
                     state_reg <= ST_PLL;
                  else
                     state_reg <= ST_RUN;
               end
            end
            ST_POWERUP_DELAY_TIMER: begin
               if (slow_tick_reg) begin
                  powerup_delay_timer_cnt_reg <= powerup_delay_timer_cnt_reg + 1'b1;
                  if (&powerup_delay_timer_cnt_reg) begin
                     if (fuse_in.xtal_mode)
                        state_reg <= ST_OST;
                     else if (fuse_in.pll_used)
                        state_reg <= ST_PLL;
                     else
                        state_reg <= ST_RUN;
                  end
               end
            end
            ST_OST: begin
               if (osc_edge) begin
                  ost_cnt_reg <= ost_cnt_reg + 11'h001;
                  if (ost_cnt_reg == 11'(OST_CYCLES - 1))
                     state_reg <= fuse_in.pll_used ? ST_PLL : ST_RUN;
               end
            end
            ST_PLL: begin
               pll_cnt_reg <= pll_cnt_reg + 17'h00001;
               if (pll_cnt_reg == 17'(PLL_CYC - 1))
                  state_reg <= ST_RUN;
            end
            ST_RUN: state_reg <= ST_RUN;
            default: state_reg <= ST_BOR;
         endcase
      end
   end

   // internal reset while any timer runs
   always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
      if (!reset_n_in)
         core_reset_out <= 1'b1;
      else
         core_reset_out <= (state_reg != ST_RUN) || bor_trip;
   end

   // first cycle after the power-on release marks the power-on event
   always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
      if (!reset_n_in)
         por_seen_reg <= 1'b0;
      else
         por_seen_reg <= 1'b1;
   end

   assign wr_en = psel_in & penable_in & pwrite_in;
   assign rd_en = psel_in & ~pwrite_in;

   // software enable resets to 0 and loads 1 in the first cycle after reset only when mode 01 is fused
   always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
      if (!reset_n_in)
         sw_enable_reg <= 1'b0;
      else if (!por_seen_reg)
         sw_enable_reg <= (fuse_in.mode_select == MODE_SW);
      else if (fuse_in.mode_select != MODE_SW)
         sw_enable_reg <= 1'b0;
      else if (wr_en && paddr_in == OFS_RESET_CTRL)
         sw_enable_reg <= pwdata_in[BIT_SW_ENABLE];
   end

   // flags: a hardware clear wins over a software set in the same cycle
   always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         bor_flag_n_reg <= 1'b0;
         por_flag_n_reg <= 1'b0;
      end else begin
         if (bor_trip && bor_en)
            bor_flag_n_reg <= 1'b0;
         else if (wr_en && paddr_in == OFS_RESET_CTRL)
            bor_flag_n_reg <= pwdata_in[BIT_BOR_FLAG];
         if (wr_en && paddr_in == OFS_RESET_CTRL)
            por_flag_n_reg <= pwdata_in[BIT_POR_FLAG];
      end
   end

   // apb read path and zero-wait answer
   always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         prdata_out  <= 32'h0000_0000;
         pready_out  <= 1'b0;
         pslverr_out <= 1'b0;
      end else begin
         pready_out  <= psel_in & ~penable_in;
         pslverr_out <= psel_in & ~penable_in &
                        (paddr_in != OFS_RESET_CTRL) & (paddr_in != OFS_STATUS);
         prdata_out  <= 32'h0000_0000;
         if (rd_en && !penable_in) begin
            if (paddr_in == OFS_RESET_CTRL) begin
               prdata_out[BIT_SW_ENABLE] <= sw_enable_reg;
               prdata_out[BIT_POR_FLAG]  <= por_flag_n_reg;
               prdata_out[BIT_BOR_FLAG]  <= bor_flag_n_reg;
            end else if (paddr_in == OFS_STATUS) begin
               prdata_out[BIT_ST_BOR_ACTIVE] <= bor_trip;
               prdata_out[BIT_ST_RESET]      <= core_reset_out;
               prdata_out[BIT_ST_BOR_EN]     <= bor_en;
               prdata_out[BIT_ST_STATE_LSB +: 5] <= state_reg;
            end
         end
      end
   end
endmodule

// ---- tb/reset_seq_monitor.sv ----
// checker: port-level properties of the brown-out and power-up reset sequencer
`timescale 1ns/1ns
module reset_seq_monitor
   import bor_seq_pkg::*;
(
   input wire logic       sys_clk_in,
   input wire logic       reset_n_in,
   input wire logic       psel_in,
   input wire logic       penable_in,
   input wire logic [7:0] paddr_in,
   input wire logic       pready_out,
   input wire logic       pslverr_out,
   input wire fuse_cfg_t  fuse_in,
   input wire logic       supply_below_in,
   input wire logic       sleep_in,
   input wire logic [1:0] trip_level_out,
   input wire logic       bor_detector_en_out,
   input wire logic       core_reset_out
);
   default clocking @(posedge sys_clk_in); endclocking
   default disable iff (!reset_n_in);
   a_level_from_fuse:
      assert property ($past(reset_n_in, 2) |-> trip_level_out == fuse_in.level_select)
      else $error("trip level not taken from fuse");
   a_mode_off_dis:
      assert property (fuse_in.mode_select == MODE_OFF |-> !bor_detector_en_out)
      else $error("detector enabled in off mode");
   a_mode_on_en:
      assert property ($past(reset_n_in, 2) && fuse_in.mode_select == MODE_ON
                       |-> bor_detector_en_out)
      else $error("detector disabled in always-on mode");
   a_sleep_dis:
      assert property ((fuse_in.mode_select == MODE_NOSLEEP && sleep_in)[*5]
                       |-> !bor_detector_en_out)
      else $error("detector still on during sleep");
   a_wake_en:
      assert property ((fuse_in.mode_select == MODE_NOSLEEP && !sleep_in)[*5]
                       |-> bor_detector_en_out)
      else $error("detector off while awake");
   a_trip_holds:
      assert property ((bor_detector_en_out && supply_below_in)[*8] |=> core_reset_out)
      else $error("no reset during sustained low supply");
   a_trip_filtered:
      assert property ($rose(core_reset_out) |-> $past(supply_below_in, 4))
      else $error("reset raised without a qualified drop");
   a_release_after:
      assert property ($fell(core_reset_out) && bor_detector_en_out
                       |-> !$past(supply_below_in, 2))
      else $error("reset released while supply still low");
   a_apb_answer:
      assert property (psel_in && !penable_in |=> pready_out && psel_in && penable_in)
      else $error("no ready in access cycle");
   a_apb_slverr:
      assert property (pready_out |-> pslverr_out ==
                       (paddr_in != OFS_RESET_CTRL && paddr_in != OFS_STATUS))
      else $error("slave error does not match address map");
endmodule
bind bor_reset_seq reset_seq_monitor mon_u (
   .sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in), .psel_in(psel_in),
   .penable_in(penable_in), .paddr_in(paddr_in), .pready_out(pready_out),
   .pslverr_out(pslverr_out), .fuse_in(fuse_in), .supply_below_in(supply_below_in),
   .sleep_in(sleep_in), .trip_level_out(trip_level_out),
   .bor_detector_en_out(bor_detector_en_out), .core_reset_out(core_reset_out)
);

// ---- tb/brownout_and_powerup_reset_ctrl_tb.sv ----
// testbench: power-up timing, brown-out, software and sleep modes of the sequencer
`timescale 1ns/1ns
module brownout_and_powerup_reset_ctrl_tb;
   import bor_seq_pkg::*;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   fuse_cfg_t   fuse = '0;
   logic        below = 1'b1;
   logic        osc = 1'b0;
   logic [1:0]  div = 2'h0;
   logic        sleep = 1'b0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [1:0]  level;
   logic        det_en;
   logic        core_rst;
   logic [31:0] rd;
   logic        err;
   int          n_errors = 0;
   int          n_compared = 0;
   always #25 clk = ~clk;
   // oscillator at a quarter of the clock rate so the synchroniser never misses an edge
   always @(posedge clk) begin
      div <= div + 2'h1;
      osc <= div[1];
   end
   bor_reset_seq #(.PLL_CYC(20), .TICK_CYC(2)) dut_u (
      .sys_clk_in(clk), .reset_n_in(rst_n), .psel_in(psel), .penable_in(penable),
      .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
      .pready_out(pready), .pslverr_out(pslverr), .fuse_in(fuse),
      .supply_below_in(below), .osc_cycle_in(osc), .sleep_in(sleep),
      .trip_level_out(level), .bor_detector_en_out(det_en), .core_reset_out(core_rst));
   task automatic final_report();
      $display("compared %0d mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int i = 0;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         i++;
      end while (pready !== 1'b1 && i < 20);
      if (pready !== 1'b1) begin
         n_errors++;
         final_report();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // counts cycles until the core leaves reset; a count reaching hi ends the run
   task automatic wait_release(input int lo, input int hi);
      int n = 0;
      while (core_rst !== 1'b0 && n < hi) begin
         @(posedge clk);
         n++;
      end
      chk("release cycles", 32'h1, {31'h0, n >= lo && n < hi});
      if (n >= hi) final_report();
   endtask
   task automatic power_up(input fuse_cfg_t f);
      @(posedge clk);
      rst_n <= 1'b0;
      fuse <= f;
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      repeat (2) @(posedge clk);
   endtask
   task automatic dip(input int n);
      @(posedge clk);
      below <= 1'b1;
      repeat (n) @(posedge clk);
      below <= 1'b0;
      repeat (2) @(posedge clk);
   endtask
   initial begin
      power_up(fuse_cfg_t'{MODE_ON, 2'h2, 1'b0, 1'b1, 1'b1});
      repeat (30) @(posedge clk);
      chk("held while low", 32'h1, {31'h0, core_rst});
      chk("trip level", 32'h2, {30'h0, level});
      apb(1'b0, OFS_RESET_CTRL, 32'h0);
      chk("flags after power-on", 32'h0, rd);
      apb(1'b1, OFS_RESET_CTRL, 32'h43);
      apb(1'b0, OFS_RESET_CTRL, 32'h0);
      // supply is still low here, so the standing trip keeps the brown-out flag cleared
      chk("sw bit outside sw mode", 32'h2, rd);
      @(posedge clk);
      below <= 1'b0;
      wait_release(8180, 8400);
      dip(2);
      repeat (20) @(posedge clk);
      chk("short dip", 32'h0, {31'h0, core_rst});
      apb(1'b1, OFS_RESET_CTRL, 32'h3);
      apb(1'b0, OFS_RESET_CTRL, 32'h0);
      chk("flags set by software", 32'h3, rd);
      dip(30);
      chk("brown-out reset", 32'h1, {31'h0, core_rst});
      apb(1'b0, OFS_RESET_CTRL, 32'h0);
      chk("flags after brown-out", 32'h2, rd);
      repeat (2000) @(posedge clk);
      dip(30);
      wait_release(8170, 8400);
      power_up(fuse_cfg_t'{MODE_SW, 2'h1, 1'b1, 1'b0, 1'b0});
      wait_release(0, 40);
      apb(1'b0, OFS_RESET_CTRL, 32'h0);
      chk("sw enable at power-on", 32'h40, rd);
      apb(1'b1, OFS_RESET_CTRL, 32'h3);
      dip(30);
      chk("sw disabled no reset", 32'h0, {30'h0, det_en, core_rst});
      apb(1'b1, OFS_RESET_CTRL, 32'h43);
      dip(30);
      chk("sw enabled reset", 32'h3, {30'h0, det_en, core_rst});
      power_up(fuse_cfg_t'{MODE_NOSLEEP, 2'h3, 1'b1, 1'b0, 1'b0});
      sleep <= 1'b1;
      dip(30);
      chk("sleep no detect", 32'h0, {30'h0, det_en, core_rst});
      sleep <= 1'b0;
      repeat (6) @(posedge clk);
      apb(1'b0, OFS_STATUS, 32'h0);
      chk("awake detect", 32'h1, {31'h0, rd[BIT_ST_BOR_EN]});
      apb(1'b0, 8'h08, 32'h0);
      chk("unmapped read data", 32'h0, rd);
      chk("unmapped read error", 32'h1, {31'h0, err});
      power_up(fuse_cfg_t'{MODE_OFF, 2'h0, 1'b1, 1'b0, 1'b0});
      dip(30);
      chk("off mode no reset", 32'h0, {30'h0, det_en, core_rst});
      final_report();
   end
   initial begin
      repeat (60000) @(posedge clk);
      n_errors++;
      final_report();
   end
endmodule
